/* include/ddrtm_pkg.sv */
// Shared constants and types for both ends of the DDR3L command timing link.
// Assumes a 25 MHz system clock; the controller halves it to make the link clock.
package ddrtm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clocking
  localparam int SYS_PERIOD_NS = 40;
  localparam int LINK_DIV = 2;
  localparam int LINK_PERIOD_NS = SYS_PERIOD_NS * LINK_DIV;

  ////////////////////////////////////////////////////////////////////////////
  // Counter type
  localparam int CNT_W = 8;
  typedef logic [CNT_W-1:0] ddrtm_cnt_t;
  localparam ddrtm_cnt_t CNT_ZERO = 8'h00;
  localparam ddrtm_cnt_t CNT_ONE = 8'h01;

  ////////////////////////////////////////////////////////////////////////////
  // Commands on the link
  localparam int ADDR_W = 8;
  typedef enum logic [3:0] {
    CMD_NOP = 4'h0,
    CMD_ACT = 4'h1,
    CMD_RD = 4'h2,
    CMD_RDA = 4'h3,
    CMD_WR = 4'h4,
    CMD_WRA = 4'h5,
    CMD_PRE = 4'h6,
    CMD_REF = 4'h7,
    CMD_MRS = 4'h8,
    CMD_SHORT_IMPEDANCE_CAL = 4'h9
  } ddrtm_cmd_t;

  // Mode register payload carried on the address lines
  localparam int MODE_CHOP4_BIT = 0;
  localparam int MODE_LEVEL_BIT = 1;
  localparam int MODE_WR_LSB = 4;
  localparam int MODE_WR_W = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Latencies in link cycles
  localparam int COL_WRITE_LAT = 5;
  localparam int ADD_LAT = 0;
  localparam int WRITE_LAT = COL_WRITE_LAT + ADD_LAT;
  localparam int TERM_LAT = WRITE_LAT - 2;
  localparam int READ_LAT = 6;
  localparam int BURST8_TAIL = 4;
  localparam int CHOP4_TAIL = 2;
  localparam ddrtm_cnt_t WL_B8_CYC = ddrtm_cnt_t'(WRITE_LAT + BURST8_TAIL);
  localparam ddrtm_cnt_t WL_C4_CYC = ddrtm_cnt_t'(WRITE_LAT + CHOP4_TAIL);
  localparam ddrtm_cnt_t RD_PD_CYC = ddrtm_cnt_t'(READ_LAT + BURST8_TAIL + 1);

  ////////////////////////////////////////////////////////////////////////////
  // Minimum spacings
  localparam int WR_RECOVERY_NS = 15;
  localparam ddrtm_cnt_t WR_REC_CYC = ddrtm_cnt_t'((WR_RECOVERY_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS);
  localparam ddrtm_cnt_t REFPD_CYC = 8'h01;
  localparam ddrtm_cnt_t MODE_UPDATE_CYC = 8'h0c;
  localparam ddrtm_cnt_t TERM_HOLD_SHORT = 8'h04;
  localparam ddrtm_cnt_t TERM_HOLD_LONG = 8'h06;
  localparam ddrtm_cnt_t LEVEL_FIRST_CYC = 8'h28;
  localparam ddrtm_cnt_t LEVEL_DRIVE_CYC = 8'h19;
  localparam int RFC_NS = 110;
  localparam ddrtm_cnt_t RFC_CYC = ddrtm_cnt_t'((RFC_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS);
  localparam int REFI_NORM_NS = 7800;
  localparam int REFI_EXT_NS = 3900;
  localparam ddrtm_cnt_t REFI_NORM_CYC = ddrtm_cnt_t'(REFI_NORM_NS / LINK_PERIOD_NS);
  localparam ddrtm_cnt_t REFI_EXT_CYC = ddrtm_cnt_t'(REFI_EXT_NS / LINK_PERIOD_NS);
  localparam int XPDLL_MIN_CYC = 10;
  localparam int XPDLL_NS = 24;
  localparam int XPDLL_NS_CYC = (XPDLL_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
  localparam ddrtm_cnt_t XPDLL_CYC = ddrtm_cnt_t'(XPDLL_MIN_CYC > XPDLL_NS_CYC ? XPDLL_MIN_CYC : XPDLL_NS_CYC);
  localparam ddrtm_cnt_t ZQ_CAL_CYC = 8'h40;

  ////////////////////////////////////////////////////////////////////////////
  // Controller power states
  typedef enum logic [1:0] {
    ST_RUN = 2'h0,
    ST_PD = 2'h1,
    ST_EXIT = 2'h3
  } ddrtm_state_t;

endpackage : ddrtm_pkg

/* include/ddrtm_link_if.sv */
// Command/address link between the memory controller and the memory device.
// The controller drives the link clock; the feedback line is resolved here.
`timescale 1ns/1ns
`default_nettype none
interface ddrtm_link_if;
  import ddrtm_pkg::*;

  logic ck;
  logic cke;
  ddrtm_cmd_t cmd;
  logic [ADDR_W-1:0] addr;
  logic chop;
  logic odt;
  logic dqs;
  logic dqs_oe;
  logic fb_o;
  logic fb_oe;
  logic dq;

  // Feedback line reads low while the device does not drive it
  assign dq = fb_oe ? fb_o : 1'b0;

  modport ctl (output ck, cke, cmd, addr, chop, odt, dqs, dqs_oe, input dq);
  modport dev (input ck, cke, cmd, addr, chop, odt, dqs, dqs_oe, output fb_o, fb_oe);

endinterface : ddrtm_link_if
`default_nettype wire

/* design/ddrtm_down_cnt.sv */
// Spacing counter: counts down once per tick, reload keeps the longer wait.
// Assumes load values of at least one cycle.
`timescale 1ns/1ns
`default_nettype none
module ddrtm_down_cnt
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic tick,
  input wire logic load,
  input wire ddrtm_pkg::ddrtm_cnt_t load_val,
  // State
  output ddrtm_pkg::ddrtm_cnt_t count,
  output logic zero
);
  import ddrtm_pkg::*;

  ddrtm_cnt_t cnt_ff;
  ddrtm_cnt_t dec;
  ddrtm_cnt_t want;
  ddrtm_cnt_t nxt_cnt;

  // Stored value n-1 lets the event fall on the n-th tick after the load
  assign dec = (tick && cnt_ff != CNT_ZERO) ? cnt_ff - CNT_ONE : cnt_ff;
  assign want = (load_val == CNT_ZERO) ? CNT_ZERO : load_val - CNT_ONE;
  assign nxt_cnt = (load && want > dec) ? want : dec;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      cnt_ff <= CNT_ZERO;
    else
      cnt_ff <= nxt_cnt;
  end

  assign count = cnt_ff;
  assign zero = (cnt_ff == CNT_ZERO);

endmodule : ddrtm_down_cnt
`default_nettype wire

/* design/ddrtm_dev_end.sv */
// Memory device end: termination latency, internal write start, refresh and calibration busy.
// Runs entirely on the link clock made by the controller; rst_n comes from elsewhere.
`timescale 1ns/1ns
`default_nettype none
module ddrtm_dev_end
(
  // Link from the controller
  ddrtm_link_if.dev lnk,
  // Local reset
  input wire logic rst_n,
  // Device status
  output logic term_on,
  output logic write_start,
  output logic refresh_busy,
  output logic cal_busy,
  output logic low_power,
  output logic level_mode
);
  import ddrtm_pkg::*;

  localparam int WP_W = WRITE_LAT + BURST8_TAIL + 1;
  localparam logic [WP_W-1:0] WP_ONE = {{(WP_W-1){1'b0}}, 1'b1};

  ////////////////////////////////////////////////////////////////////////////
  // Reset synchroniser
  logic rst_meta_ff;
  logic rst_sync_ff;

  always_ff @(posedge lnk.ck)
  begin
    rst_meta_ff <= rst_n;
    rst_sync_ff <= rst_meta_ff;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command decode
  logic cke_ff;
  logic chop4_ff;
  logic level_ff;
  logic low_power_ff;
  logic term_ff;
  logic fb_ff;
  logic [TERM_LAT:0] odt_pipe_ff;
  logic [WP_W-1:0] wr_pipe_ff;
  logic rfc_zero;
  logic zq_zero;

  wire live = lnk.cke && cke_ff;
  wire is_wr = live && (lnk.cmd == CMD_WR || lnk.cmd == CMD_WRA);
  wire is_ref = live && (lnk.cmd == CMD_REF);
  wire is_mrs = live && (lnk.cmd == CMD_MRS);
  wire is_zq = live && (lnk.cmd == CMD_SHORT_IMPEDANCE_CAL);
  wire dqs_in = lnk.dqs && lnk.dqs_oe;

  // Write start lands WL+4 edges on, WL+2 with chop-four fixed
  wire [WP_W-1:0] wr_ins = chop4_ff ? (WP_ONE << (WRITE_LAT + CHOP4_TAIL)) : (WP_ONE << (WP_W - 1));
  wire [WP_W-1:0] nxt_wr_pipe = (wr_pipe_ff >> 1) | (is_wr ? wr_ins : '0);
  // Stage TERM_LAT holds the request sampled TERM_LAT rising edges earlier
  wire [TERM_LAT:0] nxt_odt_pipe = {odt_pipe_ff[TERM_LAT-1:0], lnk.odt};
  // Low power only once refresh and write activity have drained
  wire nxt_low_power = !lnk.cke && rfc_zero && (wr_pipe_ff == '0);

  ////////////////////////////////////////////////////////////////////////////
  // Busy timers
  ddrtm_down_cnt u_rfc_cnt (
    .clk(lnk.ck),
    .rst_n(rst_sync_ff),
    .tick(1'b1),
    .load(is_ref),
    .load_val(RFC_CYC),
    .count(),
    .zero(rfc_zero)
  );

  ddrtm_down_cnt u_zq_cnt (
    .clk(lnk.ck),
    .rst_n(rst_sync_ff),
    .tick(1'b1),
    .load(is_zq),
    .load_val(ZQ_CAL_CYC),
    .count(),
    .zero(zq_zero)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Registers on the rising edge
  always_ff @(posedge lnk.ck)
  begin
    if (!rst_sync_ff)
    begin
      cke_ff <= 1'b0;
      odt_pipe_ff <= '0;
      wr_pipe_ff <= '0;
      low_power_ff <= 1'b0;
    end
    else
    begin
      cke_ff <= lnk.cke;
      odt_pipe_ff <= nxt_odt_pipe;
      wr_pipe_ff <= nxt_wr_pipe;
      low_power_ff <= nxt_low_power;
    end
  end

  always_ff @(posedge lnk.ck)
  begin
    if (!rst_sync_ff)
    begin
      chop4_ff <= 1'b0;
      level_ff <= 1'b0;
      fb_ff <= 1'b0;
    end
    else
    begin
      if (is_mrs)
      begin
        chop4_ff <= lnk.addr[MODE_CHOP4_BIT];
        level_ff <= lnk.addr[MODE_LEVEL_BIT];
      end
      fb_ff <= level_ff && dqs_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Termination switches half a cycle after the latency edge
  always_ff @(negedge lnk.ck)
  begin
    if (!rst_sync_ff)
      term_ff <= 1'b0;
    else
      term_ff <= odt_pipe_ff[TERM_LAT];
  end

  // In power-down the pin steers termination with no clock in the path
  assign term_on = low_power_ff ? lnk.odt : term_ff;
  assign write_start = wr_pipe_ff[0];
  assign refresh_busy = !rfc_zero;
  assign cal_busy = !zq_zero;
  assign low_power = low_power_ff;
  assign level_mode = level_ff;
  assign lnk.fb_o = fb_ff;
  assign lnk.fb_oe = level_ff;

endmodule : ddrtm_dev_end
`default_nettype wire

/* design/ddrtm_ctl_end.sv */
// Memory controller end: issues commands and keeps the minimum spacings on the link except the calibration busy time.
// Makes the link clock by halving sys_clk; link outputs change as the link clock falls.
`timescale 1ns/1ns
`default_nettype none
module ddrtm_ctl_end
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Link to the memory
  ddrtm_link_if.ctl lnk,
  // Command requests
  input wire logic req_valid,
  output logic req_ready,
  input wire ddrtm_pkg::ddrtm_cmd_t req_cmd,
  input wire logic [ddrtm_pkg::ADDR_W-1:0] req_addr,
  input wire logic req_chop,
  // Power, termination and refresh
  input wire logic pd_req,
  input wire logic odt_req,
  input wire logic ext_temp,
  output logic pd_active,
  output logic refresh_due,
  // Write leveling
  input wire logic lvl_pulse_req,
  output logic level_ready,
  output logic lvl_result
);
  import ddrtm_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Link clock divider
  logic ck_ff;
  wire tick = ck_ff;

  logic cke_ff;
  logic odt_ff;
  logic dqs_ff;
  logic dqs_oe_ff;
  logic chop_ff;
  logic chop4_mode_ff;
  logic level_mode_ff;
  logic fb_meta_ff;
  logic fb_sync_ff;
  logic [MODE_WR_W-1:0] wr_cyc_ff;
  logic [ADDR_W-1:0] addr_ff;
  ddrtm_cmd_t cmd_ff;
  ddrtm_state_t st_ff;
  ddrtm_state_t nxt_st;

  logic pd_zero;
  logic rfc_zero;
  logic refi_zero;
  logic hold_zero;
  logic xpdll_zero;
  logic lvl1_zero;
  logic lvl2_zero;
  ddrtm_cnt_t xpdll_cnt;

  ////////////////////////////////////////////////////////////////////////////
  // Command selection
  wire run = (st_ff == ST_RUN);
  wire needs_rfc = (req_cmd == CMD_ACT) || (req_cmd == CMD_REF);
  wire needs_dll = (req_cmd == CMD_RD) || (req_cmd == CMD_RDA);
  wire cmd_ok = !(needs_rfc && !rfc_zero) && !(needs_dll && !xpdll_zero);
  wire do_ref = run && tick && refi_zero && rfc_zero;
  assign req_ready = run && tick && !refi_zero && cmd_ok;
  wire do_req = req_valid && req_ready;
  wire issue = do_ref || do_req;

  ddrtm_cmd_t iss_cmd;
  assign iss_cmd = do_ref ? CMD_REF : req_cmd;
  wire [ADDR_W-1:0] iss_addr = do_ref ? '0 : req_addr;
  wire iss_chop = do_req && req_chop;
  wire iss_wr = issue && (iss_cmd == CMD_WR);
  wire iss_wra = issue && (iss_cmd == CMD_WRA);
  wire iss_rd = issue && (iss_cmd == CMD_RD || iss_cmd == CMD_RDA);
  wire iss_ref = issue && (iss_cmd == CMD_REF);
  wire iss_mrs = issue && (iss_cmd == CMD_MRS);
  wire iss_wx = iss_wr || iss_wra;

  ////////////////////////////////////////////////////////////////////////////
  // Power-down spacing after write, read, refresh and mode-set commands
  // On-the-fly chop keeps the eight-beat tail; only the fixed mode shortens it
  wire ddrtm_cnt_t wl_tail = chop4_mode_ff ? WL_C4_CYC : WL_B8_CYC;
  wire ddrtm_cnt_t wr_pd = wl_tail + WR_REC_CYC;
  wire ddrtm_cnt_t wra_pd = wl_tail + ddrtm_cnt_t'(wr_cyc_ff) + CNT_ONE;
  // Inside the loop-lock window after an exit, refresh also waits it out
  wire ddrtm_cnt_t ref_pd = xpdll_cnt + REFPD_CYC;
  wire ddrtm_cnt_t pd_val = iss_wr ? wr_pd : iss_wra ? wra_pd : iss_rd ? RD_PD_CYC :
                            iss_mrs ? MODE_UPDATE_CYC : ref_pd;
  wire pd_load = iss_wx || iss_rd || iss_ref || iss_mrs;

  ////////////////////////////////////////////////////////////////////////////
  // Termination hold
  wire odt_up = run && tick && odt_req && !odt_ff && xpdll_zero;
  wire hold_load = odt_up || (iss_wx && (odt_ff || odt_up));
  wire burst8 = iss_wx && !(chop4_mode_ff || iss_chop);
  wire ddrtm_cnt_t hold_val = burst8 ? TERM_HOLD_LONG : TERM_HOLD_SHORT;
  wire odt_down = tick && odt_ff && !odt_req && hold_zero && !hold_load;
  wire nxt_odt = odt_up ? 1'b1 : odt_down ? 1'b0 : odt_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Write leveling strobe
  wire mrs_lvl = iss_mrs && iss_addr[MODE_LEVEL_BIT];
  wire nxt_dqs_oe = tick ? (level_mode_ff && lvl2_zero) : dqs_oe_ff;
  wire dqs_rise = tick && lvl_pulse_req && level_ready && !dqs_ff;
  wire nxt_dqs = dqs_rise ? 1'b1 : tick ? 1'b0 : dqs_ff;
  assign level_ready = level_mode_ff && lvl1_zero && dqs_oe_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Power state
  // Refresh recovery does not hold off clock enable; the device finishes it
  wire pd_go = run && tick && !issue && !odt_up && pd_req && pd_zero && !refi_zero;
  wire pd_leave = (st_ff == ST_PD) && tick && (!pd_req || refi_zero);
  wire nxt_cke = pd_go ? 1'b0 : pd_leave ? 1'b1 : cke_ff;

  always_comb
  begin
    case (st_ff)
      ST_RUN: nxt_st = pd_go ? ST_PD : ST_RUN;
      ST_PD: nxt_st = pd_leave ? ST_EXIT : ST_PD;
      ST_EXIT: nxt_st = tick ? ST_RUN : ST_EXIT;
      default: nxt_st = ST_RUN;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Spacing counters
  ddrtm_down_cnt u_pd_cnt (
    .clk(sys_clk), .rst_n(rst_n), .tick(tick),
    .load(pd_load), .load_val(pd_val), .count(), .zero(pd_zero)
  );

  ddrtm_down_cnt u_rfc_cnt (
    .clk(sys_clk), .rst_n(rst_n), .tick(tick),
    .load(iss_ref), .load_val(RFC_CYC), .count(), .zero(rfc_zero)
  );

  ddrtm_down_cnt u_refi_cnt (
    .clk(sys_clk), .rst_n(rst_n), .tick(tick),
    .load(iss_ref), .load_val(ext_temp ? REFI_EXT_CYC : REFI_NORM_CYC), .count(), .zero(refi_zero)
  );

  ddrtm_down_cnt u_hold_cnt (
    .clk(sys_clk), .rst_n(rst_n), .tick(tick),
    .load(hold_load), .load_val(hold_val), .count(), .zero(hold_zero)
  );

  ddrtm_down_cnt u_xpdll_cnt (
    .clk(sys_clk), .rst_n(rst_n), .tick(tick),
    .load(pd_leave), .load_val(XPDLL_CYC), .count(xpdll_cnt), .zero(xpdll_zero)
  );

  ddrtm_down_cnt u_lvl1_cnt (
    .clk(sys_clk), .rst_n(rst_n), .tick(tick),
    .load(mrs_lvl), .load_val(LEVEL_FIRST_CYC), .count(), .zero(lvl1_zero)
  );

  ddrtm_down_cnt u_lvl2_cnt (
    .clk(sys_clk), .rst_n(rst_n), .tick(tick),
    .load(mrs_lvl), .load_val(LEVEL_DRIVE_CYC), .count(), .zero(lvl2_zero)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Link registers
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      ck_ff <= 1'b0;
      st_ff <= ST_RUN;
      cke_ff <= 1'b0;
      odt_ff <= 1'b0;
      dqs_ff <= 1'b0;
      dqs_oe_ff <= 1'b0;
    end
    else
    begin
      ck_ff <= !ck_ff;
      st_ff <= nxt_st;
      cke_ff <= (tick && !cke_ff && st_ff == ST_RUN) ? 1'b1 : nxt_cke;
      odt_ff <= nxt_odt;
      dqs_ff <= nxt_dqs;
      dqs_oe_ff <= nxt_dqs_oe;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      cmd_ff <= CMD_NOP;
      addr_ff <= '0;
      chop_ff <= 1'b0;
    end
    else if (tick)
    begin
      cmd_ff <= issue ? iss_cmd : CMD_NOP;
      addr_ff <= issue ? iss_addr : addr_ff;
      chop_ff <= iss_chop;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      chop4_mode_ff <= 1'b0;
      level_mode_ff <= 1'b0;
      wr_cyc_ff <= '0;
    end
    else if (iss_mrs)
    begin
      chop4_mode_ff <= iss_addr[MODE_CHOP4_BIT];
      level_mode_ff <= iss_addr[MODE_LEVEL_BIT];
      wr_cyc_ff <= iss_addr[MODE_WR_LSB +: MODE_WR_W];
    end
  end

  // Feedback comes from the device's domain
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      fb_meta_ff <= 1'b0;
      fb_sync_ff <= 1'b0;
    end
    else
    begin
      fb_meta_ff <= lnk.dq;
      fb_sync_ff <= fb_meta_ff;
    end
  end

  assign lnk.ck = ck_ff;
  assign lnk.cke = cke_ff;
  assign lnk.cmd = cmd_ff;
  assign lnk.addr = addr_ff;
  assign lnk.chop = chop_ff;
  assign lnk.odt = odt_ff;
  assign lnk.dqs = dqs_ff;
  assign lnk.dqs_oe = dqs_oe_ff;
  assign pd_active = (st_ff == ST_PD);
  assign refresh_due = refi_zero;
  assign lvl_result = fb_sync_ff;

endmodule : ddrtm_ctl_end
`default_nettype wire

/* dv/ddrtm_link_properties.sv */
// Checker for the command link between the controller end and the device end.
// Assumes link signals as plain inputs; the link clock stands still while rst_n is low.
`timescale 1ns/1ns
`default_nettype none
module ddrtm_link_properties
(
  // Link clock and reset
  input wire logic ck,
  input wire logic rst_n,
  // Controller side
  input wire logic cke,
  input wire ddrtm_pkg::ddrtm_cmd_t cmd,
  input wire logic [ddrtm_pkg::ADDR_W-1:0] addr,
  input wire logic chop,
  input wire logic odt,
  input wire logic dqs,
  input wire logic dqs_oe,
  // Device side
  input wire logic fb_o,
  input wire logic fb_oe,
  input wire logic dq
);
  import ddrtm_pkg::*;

  logic fix_ff;
  logic pd_ff;
  ddrtm_cnt_t lvl_ff;
  ddrtm_cnt_t ref_ff;
  wire logic is_mode = cmd == CMD_MRS;
  wire logic wr8 = cmd == CMD_WR && !chop && !fix_ff;
  wire logic rd = cmd == CMD_RD || cmd == CMD_RDA;

  default clocking cb @(posedge ck); endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////////
  // Mode tracking; asynchronous reset because the link clock stops in reset
  always_ff @(posedge ck or negedge rst_n)
    if (!rst_n)
    begin
      fix_ff <= 1'b0;
      pd_ff <= 1'b0;
    end
    else
    begin
      fix_ff <= is_mode ? addr[MODE_CHOP4_BIT] : fix_ff;
      pd_ff <= pd_ff || (!cke && ref_ff != CNT_ZERO);
    end

  // Cycles since leveling was programmed, saturating
  always_ff @(posedge ck or negedge rst_n)
    if (!rst_n)
      lvl_ff <= 8'hff;
    else if (is_mode)
      lvl_ff <= addr[MODE_LEVEL_BIT] ? CNT_ONE : 8'hff;
    else if (lvl_ff != 8'hff)
      lvl_ff <= lvl_ff + CNT_ONE;

  // Cycles since the last refresh, saturating
  always_ff @(posedge ck or negedge rst_n)
    if (!rst_n)
      ref_ff <= CNT_ZERO;
    else if (cmd == CMD_REF)
      ref_ff <= CNT_ONE;
    else if (ref_ff != 8'hff)
      ref_ff <= ref_ff + CNT_ONE;

  ////////////////////////////////////////////////////////////////////////////
  a_wr_pd_gap: assert property (wr8 |=> cke [*8] ##1 cke)
    else $error("power-down too soon after write");
  a_chop_pd_gap: assert property (cmd == CMD_WR && fix_ff |=> cke [*7])
    else $error("power-down too soon after chopped write");
  a_mode_pd_gap: assert property (is_mode |=> cke [*8] ##1 cke [*3])
    else $error("power-down too soon after mode set");
  a_ref_spacing: assert property (cmd == CMD_REF |=> cmd != CMD_REF && cmd != CMD_ACT)
    else $error("refresh cycle time broken");
  a_odt_hold_short: assert property ($rose(odt) |-> odt [*4])
    else $error("termination request too short");
  a_odt_hold_long: assert property (wr8 && odt |-> odt [*6])
    else $error("termination request too short with write");
  a_strobe_first: assert property (dqs |-> lvl_ff >= LEVEL_FIRST_CYC)
    else $error("leveling strobe too early");
  a_strobe_drive: assert property (dqs_oe |-> lvl_ff >= LEVEL_DRIVE_CYC)
    else $error("leveling strobe driven too early");
  a_level_feedback: assert property (fb_oe |-> fb_o == $past(dqs) && dq == fb_o)
    else $error("leveling feedback wrong");
  a_ref_interval: assert property (ref_ff <= REFI_NORM_CYC + 8'h04)
    else $error("refresh interval exceeded");
  a_read_lock: assert property ($rose(cke) && pd_ff |-> !rd [*8] ##1 !rd [*2])
    else $error("read before loop lock");

  c_write8: cover property (wr8);
  c_strobe: cover property (dqs);
  c_power_down: cover property ($fell(cke));

endmodule : ddrtm_link_properties
`default_nettype wire

/* dv/ddr3l_cmd_timing_rules_bench.sv */
// Self-checking bench: both ends joined by the link, requests made on the system side.
// Assumes package, interface and design files are compiled first.
`timescale 1ns/1ns
`default_nettype none
module ddr3l_cmd_timing_rules_bench;
  import ddrtm_pkg::*;

  logic sys_clk, rst_n, dev_rst_n, req_valid, req_chop, pd_req, odt_req, ext_temp, lvl_pulse_req;
  ddrtm_cmd_t req_cmd;
  logic [ADDR_W-1:0] req_addr;
  logic req_ready, pd_active, refresh_due, level_ready, lvl_result;
  logic term_on, write_start, refresh_busy, cal_busy, low_power, level_mode;
  int n_errors, check_count, n;
  ddrtm_cmd_t pool [8] = '{CMD_ACT, CMD_RD, CMD_RDA, CMD_WR, CMD_WRA, CMD_PRE, CMD_REF, CMD_SHORT_IMPEDANCE_CAL};

  ddrtm_link_if lnk ();
  ddrtm_ctl_end u_ddrtm_ctl_end (.sys_clk, .rst_n, .lnk, .req_valid, .req_ready, .req_cmd, .req_addr,
    .req_chop, .pd_req, .odt_req, .ext_temp, .pd_active, .refresh_due, .lvl_pulse_req, .level_ready, .lvl_result);
  ddrtm_dev_end u_ddrtm_dev_end (.lnk, .rst_n(dev_rst_n), .term_on, .write_start, .refresh_busy, .cal_busy,
    .low_power, .level_mode);
  ddrtm_link_properties u_ddrtm_link_properties (.ck(lnk.ck), .rst_n, .cke(lnk.cke), .cmd(lnk.cmd),
    .addr(lnk.addr), .chop(lnk.chop), .odt(lnk.odt), .dqs(lnk.dqs), .dqs_oe(lnk.dqs_oe), .fb_o(lnk.fb_o),
    .fb_oe(lnk.fb_oe), .dq(lnk.dq));

  ////////////////////////////////////////////////////////////////////////////
  function automatic int exp_ws(input logic fix);
    return WRITE_LAT + (fix ? CHOP4_TAIL : BURST8_TAIL);
  endfunction : exp_ws

  function automatic int exp_pd(input logic wr, input logic fix, input int rec);
    return exp_ws(fix) + (wr ? int'(WR_REC_CYC) : rec + 1);
  endfunction : exp_pd

  function automatic logic seen(input int s);
    case (s)
      0: return write_start;
      1: return term_on;
      2: return !term_on;
      3: return !lnk.cke;
      4: return lnk.cke;
      5: return lnk.odt;
      6: return !lnk.odt;
      7: return !cal_busy;
      8: return level_ready;
      9: return lnk.dqs;
      10: return lvl_result;
      11: return low_power;
      default: return !refresh_busy;
    endcase
  endfunction : seen

  task automatic check(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1)
    begin
      n_errors++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask : check

  // Counts link edges until the condition holds, sampling just after each edge
  task automatic wait_for(input int s, output int k);
    k = 0;
    do
    begin
      @(posedge lnk.ck);
      #1;
      k++;
    end
    while (seen(s) !== 1'b1 && k < 200);
  endtask : wait_for

  task automatic send(input ddrtm_cmd_t c, input logic [7:0] a, input logic ch);
    int k;
    @(posedge sys_clk);
    req_cmd <= c;
    req_addr <= a;
    req_chop <= ch;
    req_valid <= 1'b1;
    k = 0;
    do
    begin
      @(negedge sys_clk);
      k++;
    end
    while (req_ready !== 1'b1 && k < 500);
    @(posedge sys_clk);
    req_valid <= 1'b0;
    @(posedge lnk.ck);
    check(lnk.cmd === c, "command not on link");
  endtask : send

  task automatic end_sim();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_sim

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  initial
  begin
    #1000000;
    n_errors++;
    $display("Error at %0t: watchdog expired", $time);
    end_sim();
  end

  initial
  begin
    {rst_n, dev_rst_n, req_valid, req_chop, pd_req, odt_req, ext_temp, lvl_pulse_req} = 8'h00;
    req_cmd = CMD_NOP;
    req_addr = 8'h00;
    n_errors = 0;
    check_count = 0;
    void'($urandom(32'h8076a648));
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (12) @(posedge sys_clk);
    dev_rst_n <= 1'b1;
    ext_temp <= 1'($urandom);
    repeat (8) @(posedge sys_clk);
    for (int m = 0; m < 4; m++)
    begin
      send(CMD_MRS, {4'h1, 3'h0, m[1]}, 1'b0);
      send(CMD_WR, 8'($urandom), m[0]);
      wait_for(0, n);
      check(n == exp_ws(m[1]), "internal write start");
    end
    $display("test write start done");
    @(posedge sys_clk);
    odt_req <= 1'b1;
    wait_for(5, n);
    wait_for(1, n);
    check(n == TERM_LAT + 1, "termination on latency");
    @(posedge sys_clk);
    odt_req <= 1'b0;
    wait_for(6, n);
    wait_for(2, n);
    check(n == TERM_LAT + 1, "termination off latency");
    $display("test termination done");
    send(CMD_SHORT_IMPEDANCE_CAL, 8'($urandom), 1'b0);
    wait_for(7, n);
    check(n > 1 && n <= ZQ_CAL_CYC, "calibration length");
    $display("test calibration done");
    send(CMD_MRS, 8'h12, 1'b0);
    wait_for(8, n);
    check(level_mode === 1'b1, "leveling mode");
    @(posedge sys_clk);
    lvl_pulse_req <= 1'b1;
    wait_for(9, n);
    @(posedge sys_clk);
    lvl_pulse_req <= 1'b0;
    wait_for(10, n);
    check(n < 6, "leveling feedback");
    send(CMD_MRS, 8'h10, 1'b0);
    $display("test leveling done");
    for (int k = 0; k < 4; k++)
    begin
      send(CMD_MRS, {4'h3, 3'h0, k[0]}, 1'b0);
      send(k[1] ? CMD_WR : CMD_WRA, 8'($urandom), 1'b0);
      pd_req <= 1'b1;
      odt_req <= k[0];
      wait_for(3, n);
      check(n >= exp_pd(k[1], k[0], 3), "power-down spacing");
      wait_for(11, n);
      check(pd_active === 1'b1 && low_power === 1'b1, "power-down state");
      odt_req <= 1'b0;
      wait_for(6, n);
      check(term_on === 1'b0 && low_power === 1'b1, "termination follows request in power-down");
      @(posedge sys_clk);
      pd_req <= 1'b0;
      wait_for(4, n);
      check(n < 10, "power-down exit");
      send(CMD_RD, 8'($urandom), 1'b0);
    end
    $display("test power-down done");
    send(CMD_MRS, 8'h10, 1'b0);
    odt_req <= 1'b1;
    send(CMD_WR, 8'($urandom), 1'b0);
    odt_req <= 1'b0;
    wait_for(6, n);
    check(n == TERM_HOLD_LONG, "termination hold with write");
    send(CMD_REF, 8'h00, 1'b0);
    #1;
    check(refresh_busy === 1'b1 && refresh_due === 1'b0, "refresh start");
    wait_for(12, n);
    check(n == RFC_CYC - 1, "refresh busy length");
    $display("test spacing done");
    for (int i = 0; i < 24; i++)
    begin
      odt_req <= 1'($urandom);
      send(pool[$urandom_range(7)], 8'($urandom), 1'($urandom));
    end
    $display("test random traffic done");
    end_sim();
  end

endmodule : ddr3l_cmd_timing_rules_bench
`default_nettype wire
